// >>> src/scpn_port.sv
/*
  Serial configuration port: command interpreter, status register,
  configuration words and a modelled nonvolatile store.
  Assumes the host keeps the speed-pulse pin released while it talks.
*/
`timescale 1ns/10ps
module scpn_port
  import scpn_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_sck,
  input  wire logic       i_sdi,
  input  wire logic       i_pulse_hiz,
  input  wire logic       i_cal_fail,
  output logic            o_fault_out,
  output logic            o_sdio_out,
  output logic            o_sdio_oe_n,
  output logic            o_no_feedback_select,
  output logic            o_command_source_select,
  output logic            o_pulse_pin_source,
  output logic [6:0]      o_integral_gain,
  output logic            o_integral_gain_x8,
  output logic [6:0]      o_proportional_gain,
  output logic            o_proportional_gain_x8,
  output logic            o_standby_request,
  output logic            o_dir_map,
  output logic            o_sensor_polarity_flip,
  output logic            o_commutation_scheme_select,
  output logic            o_current_limit_off,
  output logic            o_command_polarity_flip
);
  // ==========================================================
  // Input synchronisers
  logic [1:0] sck_sync_ff;
  logic [1:0] sdi_sync_ff;
  logic [1:0] hiz_sync_ff;
  logic       sck_prev_ff;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sck_sync_ff <= 2'h0;
      sdi_sync_ff <= 2'h0;
      hiz_sync_ff <= 2'h0;
      sck_prev_ff <= 1'b0;
    end else begin
      sck_sync_ff <= {sck_sync_ff[0], i_sck};
      sdi_sync_ff <= {sdi_sync_ff[0], i_sdi};
      hiz_sync_ff <= {hiz_sync_ff[0], i_pulse_hiz};
      sck_prev_ff <= sck_sync_ff[1];
    end
  end
  wire sck_rise = sck_sync_ff[1] & ~sck_prev_ff;
  wire port_on  = hiz_sync_ff[1];

  // ==========================================================
  // Frame handling
  // A frame opens when the speed-pulse pin is released and the
  // synchronised release has been seen; any drop of the release
  // throws away the partial frame and returns to command capture.
  // A host must therefore drop the release between two frames,
  // otherwise the port waits in the done state and ignores traffic.
  //
  // Every serial bit, in and out, is handled on the core edge at
  // which the synchronised serial clock is found rising. With two
  // synchroniser stages and one edge register this is about three
  // core clocks after the pin edge, so each serial clock phase
  // must last at least four core clocks.
  //
  // Outgoing data: the first bit is loaded on the rising edge that
  // completes the command or address field, and the register
  // shifts on each later rising edge. A bit therefore stands for a
  // whole serial period and the host may sample it at any time
  // while the serial clock is low before the next rise. Shifting
  // on the falling edge instead would lose the first bit, since a
  // fall follows the loading rise before the host has sampled.
  //
  // Refused traffic: with the gate closed only the two status
  // commands run; anything else, and any unknown code, sends the
  // port to the done state, where remaining bits are ignored.
  // Addresses from eleven up read as zero and ignore writes.
  //
  // Storage engine: a store runs for a fixed number of core clocks
  // and commits all saved words at its end only, so a cancel in
  // the middle leaves the old storage image untouched. A recall
  // overwrites words 0 to 9 in one clock and leaves word 10 alone.
  // Store is refused outside program mode, recall inside it.

  // ==========================================================
  // Storage
  logic [15:0] word_ff [WORD_COUNT];
  logic [15:0] nv_ff   [WORD_COUNT-1];
  logic [7:0]  status_ff;
  logic [7:0]  nxt_status;

  typedef enum logic [2:0] {SCPN_CMD, SCPN_ADR, SCPN_RX, SCPN_TX, SCPN_DONE} scpn_state_t;
  scpn_state_t state_ff;
  scpn_state_t nxt_state;
  logic [7:0]  cmd_ff;
  logic [7:0]  adr_ff;
  logic [15:0] sh_ff;
  logic [4:0]  cnt_ff;
  logic        prog_ff;
  logic [31:0] prog_cnt_ff;
  logic        recall_ff;

  function automatic logic valid_nv_adr(input logic [7:0] a);
    return a <= NV_LAST_ADR;
  endfunction : valid_nv_adr

  function automatic logic valid_adr(input logic [7:0] a);
    return a < 8'(WORD_COUNT);
  endfunction : valid_adr

  wire [7:0] cmd_now   = {sh_ff[6:0], sdi_sync_ff[1]};
  wire       gate      = status_ff[ST_GATE_BIT];
  wire       is_status = (cmd_now == STATUS_FETCH_CMD) | (cmd_now == STATUS_PUT_CMD);
  wire       allowed   = is_status | gate;
  wire       last_bit  = (cnt_ff == 5'h0);
  wire       two_wire  = status_ff[ST_WIRE_BIT];
  wire       prog_mode = status_ff[ST_PROG_BIT];
  wire [15:0] rx_word  = {sh_ff[14:0], sdi_sync_ff[1]};
  wire       cmd_done  = port_on & sck_rise & (state_ff == SCPN_CMD) & (cnt_ff == 5'h7);
  wire       start_store  = cmd_done & gate & (cmd_now == STORAGE_STORE_CMD) & prog_mode & ~prog_ff;
  wire       start_recall = cmd_done & gate & (cmd_now == STORAGE_RECALL_CMD) & ~prog_mode;
  wire       do_cancel    = cmd_done & gate & (cmd_now == STORAGE_CANCEL_CMD);
  wire       prog_end     = prog_ff & (prog_cnt_ff == 32'(PROG_CYC - 1));
  wire       put_status   = port_on & sck_rise & (state_ff == SCPN_RX) & last_bit & (cmd_ff == STATUS_PUT_CMD);
  wire       put_word     = port_on & sck_rise & (state_ff == SCPN_RX) & last_bit & (cmd_ff == WORD_PUT_CMD);

  // ==========================================================
  // Serial state machine
  always_comb begin
    nxt_state = state_ff;
    if (!port_on) begin
      nxt_state = SCPN_CMD;
    end else if (sck_rise) begin
      unique case (state_ff)
        SCPN_CMD: begin
          if (cnt_ff == 5'h7) begin
            if (!allowed) nxt_state = SCPN_DONE;
            else if (cmd_now == STATUS_FETCH_CMD) nxt_state = SCPN_TX;
            else if (cmd_now == STATUS_PUT_CMD) nxt_state = SCPN_RX;
            else if (cmd_now == WORD_FETCH_CMD || cmd_now == WORD_PUT_CMD) nxt_state = SCPN_ADR;
            else nxt_state = SCPN_DONE;
          end
        end
        SCPN_ADR: begin
          if (last_bit) nxt_state = (cmd_ff == WORD_PUT_CMD) ? SCPN_RX : SCPN_TX;
        end
        SCPN_RX, SCPN_TX: begin
          if (last_bit) nxt_state = SCPN_DONE;
        end
        SCPN_DONE: nxt_state = SCPN_DONE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= SCPN_CMD;
      cmd_ff   <= 8'h00;
      adr_ff   <= 8'h00;
      sh_ff    <= 16'h0000;
      cnt_ff   <= 5'h0;
    end else begin
      state_ff <= nxt_state;
      if (!port_on) begin
        cnt_ff <= 5'h0;
        sh_ff  <= 16'h0000;
      end else if (sck_rise) begin
        unique case (state_ff)
          SCPN_CMD: begin
            sh_ff  <= rx_word;
            cnt_ff <= cnt_ff + 5'h1;
            if (cnt_ff == 5'h7) begin
              cmd_ff <= cmd_now;
              cnt_ff <= (cmd_now == STATUS_FETCH_CMD || cmd_now == STATUS_PUT_CMD) ? 5'h7 : 5'h7;
              if (cmd_now == STATUS_FETCH_CMD) sh_ff <= {status_ff, 8'h00};
            end
          end
          SCPN_ADR: begin
            sh_ff  <= rx_word;
            cnt_ff <= cnt_ff - 5'h1;
            if (last_bit) begin
              adr_ff <= rx_word[7:0];
              cnt_ff <= 5'hf;
              sh_ff  <= (valid_adr(rx_word[7:0])) ? word_ff[rx_word[3:0]] : 16'h0000;
            end
          end
          SCPN_RX: begin
            sh_ff  <= rx_word;
            cnt_ff <= cnt_ff - 5'h1;
          end
          SCPN_TX: begin
            sh_ff  <= {sh_ff[14:0], 1'b0};
            cnt_ff <= cnt_ff - 5'h1;
          end
          SCPN_DONE: cnt_ff <= cnt_ff;
        endcase
      end
    end
  end

  // ==========================================================
  // Outgoing data pins
  wire tx_bit = (cmd_ff == STATUS_FETCH_CMD) ? sh_ff[15] : sh_ff[15];
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_fault_out <= 1'b1;
      o_sdio_out  <= 1'b1;
      o_sdio_oe_n <= 1'b1;
    end else begin
      o_fault_out <= (!two_wire && state_ff == SCPN_TX) ? tx_bit : 1'b1;
      o_sdio_out  <= tx_bit;
      o_sdio_oe_n <= ~(two_wire && port_on && state_ff == SCPN_TX);
    end
  end

  // ==========================================================
  // Status register and storage engine
  always_comb begin
    nxt_status = status_ff;
    if (put_status) nxt_status = (status_ff & ~ST_WRITE_MASK) | (rx_word[7:0] & ST_WRITE_MASK);
    nxt_status[ST_CAL_BIT]  = i_cal_fail;
    nxt_status[ST_BUSY_BIT] = prog_ff | recall_ff;
    nxt_status[7:5] = 3'h0;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status_ff   <= STATUS_RESET;
      prog_ff     <= 1'b0;
      prog_cnt_ff <= 32'h0;
      recall_ff   <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      recall_ff <= start_recall;
      if (do_cancel || prog_end) begin
        prog_ff <= 1'b0;
      end else if (start_store) begin
        prog_ff <= 1'b1;
      end
      prog_cnt_ff <= prog_ff ? prog_cnt_ff + 32'h1 : 32'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < WORD_COUNT; i++) word_ff[i] <= WORD_RESET;
    end else if (put_word && valid_adr(adr_ff)) begin
      word_ff[adr_ff[3:0]] <= rx_word;
    end else if (start_recall) begin
      for (int i = 0; i < WORD_COUNT - 1; i++) word_ff[i] <= nv_ff[i];
    end
  end

  // Storage contents survive core reset and are committed only at the end of programming.
  always_ff @(posedge i_clk) begin
    if (prog_end && !do_cancel) begin
      for (int i = 0; i < WORD_COUNT - 1; i++) nv_ff[i] <= word_ff[i];
    end
  end

  // ==========================================================
  // Configuration outputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_no_feedback_select        <= 1'b0;
      o_command_source_select     <= 1'b0;
      o_pulse_pin_source          <= 1'b0;
      o_integral_gain             <= 7'h00;
      o_integral_gain_x8          <= 1'b0;
      o_proportional_gain         <= 7'h00;
      o_proportional_gain_x8      <= 1'b0;
      o_standby_request           <= 1'b0;
      o_dir_map                   <= 1'b0;
      o_sensor_polarity_flip      <= 1'b0;
      o_commutation_scheme_select <= 1'b0;
      o_current_limit_off         <= 1'b0;
      o_command_polarity_flip     <= 1'b0;
    end else begin
      o_no_feedback_select        <= word_ff[ADR_SLOPE2[3:0]][B_NO_FEEDBACK];
      o_command_source_select     <= word_ff[ADR_DRIVE[3:0]][B_CMD_SRC];
      o_pulse_pin_source          <= word_ff[ADR_DRIVE[3:0]][B_PULSE_SRC];
      o_integral_gain             <= word_ff[ADR_GAIN[3:0]][14:8];
      o_integral_gain_x8          <= word_ff[ADR_GAIN[3:0]][15];
      o_proportional_gain         <= word_ff[ADR_GAIN[3:0]][6:0];
      o_proportional_gain_x8      <= word_ff[ADR_GAIN[3:0]][7];
      o_standby_request           <= word_ff[ADR_SETUP[3:0]][B_STANDBY];
      o_dir_map                   <= word_ff[ADR_SETUP[3:0]][B_DIR_MAP];
      o_sensor_polarity_flip      <= word_ff[ADR_SETUP[3:0]][B_SENSOR_FLIP];
      o_commutation_scheme_select <= word_ff[ADR_DRIVE[3:0]][B_COMMUTATION];
      o_current_limit_off         <= word_ff[ADR_DRIVE[3:0]][B_CURLIM_OFF];
      o_command_polarity_flip     <= word_ff[ADR_DRIVE[3:0]][B_CMD_FLIP];
    end
  end
endmodule : scpn_port

// >>> common/scpn_pkg.sv
/*
  Constants for the serial configuration port with nonvolatile backing.
  Assumes a single 100 MHz core clock and a host-driven serial clock.
*/
package scpn_pkg;
  // ==========================================================
  // Command codes
  localparam logic [7:0] STATUS_FETCH_CMD   = 8'h49;
  localparam logic [7:0] STATUS_PUT_CMD     = 8'h4a;
  localparam logic [7:0] WORD_FETCH_CMD     = 8'h51;
  localparam logic [7:0] WORD_PUT_CMD       = 8'h52;
  localparam logic [7:0] STORAGE_RECALL_CMD = 8'h59;
  localparam logic [7:0] STORAGE_STORE_CMD  = 8'h5a;
  localparam logic [7:0] STORAGE_CANCEL_CMD = 8'h5c;
  // ==========================================================
  // Status bits
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_GATE_BIT  = 1;
  localparam int ST_WIRE_BIT  = 2;
  localparam int ST_PROG_BIT  = 3;
  localparam int ST_CAL_BIT   = 4;
  localparam logic [7:0] ST_WRITE_MASK = 8'h0e;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  // ==========================================================
  // Configuration words
  localparam int          WORD_COUNT  = 11;
  localparam logic [7:0]  NV_LAST_ADR = 8'h09;
  localparam logic [7:0]  ADR_SLOPE2  = 8'h05;
  localparam logic [7:0]  ADR_GAIN    = 8'h06;
  localparam logic [7:0]  ADR_SETUP   = 8'h07;
  localparam logic [7:0]  ADR_DRIVE   = 8'h08;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam int B_NO_FEEDBACK  = 0;
  localparam int B_STANDBY      = 15;
  localparam int B_DIR_MAP      = 14;
  localparam int B_SENSOR_FLIP  = 8;
  localparam int B_PULSE_SRC    = 15;
  localparam int B_CMD_SRC      = 11;
  localparam int B_CMD_FLIP     = 10;
  localparam int B_COMMUTATION  = 8;
  localparam int B_CURLIM_OFF   = 5;
  // ==========================================================
  // Timing
  localparam int CLK_NS          = 10;
  localparam int PROG_TIME_US    = 10;
  localparam int PROG_CYCLES     = PROG_TIME_US * 1000 / CLK_NS;
endpackage : scpn_pkg

// >>> sim/scpn_port_props.sv
/*
  Port-level checker for the serial configuration port.
  Assumes it is bound to scpn_port and sees only its ports.
*/
`timescale 1ns/10ps
module scpn_port_props
  import scpn_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_pulse_hiz,
  input  wire logic       o_fault_out,
  input  wire logic       o_sdio_oe_n,
  input  wire logic       o_no_feedback_select,
  input  wire logic       o_standby_request,
  input  wire logic       o_pulse_pin_source,
  input  wire logic       o_command_source_select,
  input  wire logic [6:0] o_integral_gain,
  input  wire logic [6:0] o_proportional_gain
);
  // ==========================================================
  // Pin ownership and configuration stability
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_reset_idle: assert property ($past(i_rst) |-> o_fault_out && o_sdio_oe_n && !o_standby_request)
    else $error("outputs not idle after reset");
  a_release_on_drop: assert property ($fell(i_pulse_hiz) |-> ##[1:4] (o_sdio_oe_n && o_fault_out))
    else $error("pin not released after frame drop");
  a_drive_in_frame: assert property (!o_sdio_oe_n |-> $past(i_pulse_hiz, 6))
    else $error("pin driven outside a frame");
  a_pin_single_use: assert property (!o_sdio_oe_n |-> o_fault_out)
    else $error("fault pin moves in two-wire output");
  a_oe_hold: assert property ($fell(o_sdio_oe_n) |-> !o_sdio_oe_n [*8])
    else $error("data pin drive too short");
  a_fault_idle: assert property (!i_pulse_hiz [*4] |-> o_fault_out)
    else $error("fault pin not idle between frames");
  a_cfg_standby: assert property ($changed(o_standby_request) |-> $past(i_pulse_hiz, 4))
    else $error("standby changed outside a frame");
  a_cfg_gain: assert property (!i_pulse_hiz [*5] |-> $stable(o_integral_gain) && $stable(o_proportional_gain))
    else $error("gains changed between frames");
  a_cfg_drive: assert property ($changed({o_pulse_pin_source, o_command_source_select, o_no_feedback_select})
    |-> i_pulse_hiz && $past(i_pulse_hiz, 3))
    else $error("drive config changed outside a frame");
endmodule : scpn_port_props
bind scpn_port scpn_port_props #(.PROG_CYC(PROG_CYC)) scpn_port_props_i (.i_clk, .i_rst, .i_pulse_hiz,
  .o_fault_out, .o_sdio_oe_n, .o_no_feedback_select, .o_standby_request, .o_pulse_pin_source,
  .o_command_source_select, .o_integral_gain, .o_proportional_gain);

// >>> sim/scpn_host.sv
/*
  Behavioural host on the far side of the serial port.
  Assumes the bench resolves the shared data pin from the port's enable alone.
*/
`timescale 1ns/10ps
module scpn_host (
  input  wire logic i_fault,
  input  wire logic i_sdio,
  output logic      o_sck,
  output logic      o_sdo,
  output logic      o_hiz
);
  initial begin
    o_sck = 1'b0;
    o_sdo = 1'b1;
    o_hiz = 1'b1;
  end
  // ==========================================================
  // One framed transfer; serial clock stands low between frames
  task automatic xfer(input logic [7:0] c, input int nin, input logic [23:0] din, input int nout,
                      input bit tw, output logic [15:0] dout);
    logic [31:0] sh;
    sh = {c, din << (24 - nin)};
    dout = '0;
    o_hiz = 1'b0;
    #40 o_hiz = 1'b1;
    #60;
    for (int k = 0; k < 8 + nin + nout; k++) begin
      if (k < 8 + nin) o_sdo = sh[31 - k];
      else o_sdo = ~o_sdo;
      #62.5;
      if (k >= 8 + nin) dout = {dout[14:0], tw ? i_sdio : i_fault};
      o_sck = 1'b1;
      #62.5 o_sck = 1'b0;
    end
    o_sdo = ~o_sdo;
    #200;
  endtask : xfer
endmodule : scpn_host

// >>> sim/tb_top.sv
/*
  Self-checking bench for the serial configuration port.
  Assumes the host model drives all serial traffic.
*/
`timescale 1ns/10ps
module tb_top;
  import scpn_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_cal_fail = 1'b0, tw = 1'b0;
  logic sck, sdo, hiz, fault, sdio, oe_n, sdio_w, nfb, csrc, psrc, integral_gain_x8, proportional_gain_x8, standby_request, dmap, sflip, comm, clo, cflip;
  logic [6:0] ki, kp;
  logic [15:0] rd;
  logic [24:0] cfg;
  logic [15:0] ws [2][4] = '{'{16'h0001, 16'h8a05, 16'hc100, 16'h8d20}, '{16'hfffe, 16'h757a, 16'h3eff, 16'h72df}};
  int num_errors = 0, total_checks = 0;
  always #5 i_clk = ~i_clk;
  assign sdio_w = !oe_n ? sdio : sdo;
  assign cfg = {psrc, csrc, cflip, comm, clo, nfb, standby_request, dmap, sflip, integral_gain_x8, ki, proportional_gain_x8, kp};
  scpn_port #(.PROG_CYC(300)) scpn_port_i (.i_clk(i_clk), .i_rst(i_rst), .i_sck(sck), .i_sdi(sdio_w),
    .i_pulse_hiz(hiz), .i_cal_fail(i_cal_fail), .o_fault_out(fault), .o_sdio_out(sdio), .o_sdio_oe_n(oe_n),
    .o_no_feedback_select(nfb), .o_command_source_select(csrc), .o_pulse_pin_source(psrc),
    .o_integral_gain(ki), .o_integral_gain_x8(integral_gain_x8), .o_proportional_gain(kp), .o_proportional_gain_x8(proportional_gain_x8),
    .o_standby_request(standby_request), .o_dir_map(dmap), .o_sensor_polarity_flip(sflip),
    .o_commutation_scheme_select(comm), .o_current_limit_off(clo), .o_command_polarity_flip(cflip));
  scpn_host scpn_host_i (.i_fault(fault), .i_sdio(sdio_w), .o_sck(sck), .o_sdo(sdo), .o_hiz(hiz));
  // ==========================================================
  // Access and compare tasks
  task automatic chk(input string nm, input logic [24:0] exp, input logic [24:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] c, input int nin = 0, input logic [23:0] din = '0, input int nout = 0);
    @(posedge i_clk) #1;
    scpn_host_i.xfer(c, nin, din, nout, tw, rd);
  endtask : cmd
  task automatic st_put(input logic [7:0] v);
    cmd(STATUS_PUT_CMD, 8, {16'h0000, v});
  endtask : st_put
  task automatic st_get(input logic [7:0] exp);
    cmd(STATUS_FETCH_CMD, 0, '0, 8);
    chk("status", {17'h0, exp}, {9'h0, rd});
  endtask : st_get
  task automatic wget(input logic [7:0] a, input logic [15:0] exp);
    cmd(WORD_FETCH_CMD, 8, {16'h0000, a}, 16);
    chk("word", {9'h0, exp}, {9'h0, rd});
  endtask : wget
  function automatic logic [24:0] ecfg(input int s);
    logic [15:0] w5, w6, w7, w8;
    {w5, w6, w7, w8} = {ws[s][0], ws[s][1], ws[s][2], ws[s][3]};
    return {w8[B_PULSE_SRC], w8[B_CMD_SRC], w8[B_CMD_FLIP], w8[B_COMMUTATION], w8[B_CURLIM_OFF], w5[B_NO_FEEDBACK],
            w7[B_STANDBY], w7[B_DIR_MAP], w7[B_SENSOR_FLIP], w6[15], w6[14:8], w6[7], w6[6:0]};
  endfunction : ecfg
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  initial begin
    #900us;
    num_errors++;
    wrap_up();
  end
  // ==========================================================
  // Test sequence
  initial begin
    repeat (5) @(posedge i_clk);
    #1 i_rst = 1'b0;
    chk("cfg", 25'h0, cfg);
    st_get(8'h00);
    cmd(WORD_PUT_CMD, 24, {ADR_GAIN, 16'hffff});
    chk("cfg", 25'h0, cfg);
    st_put(8'hf3);
    st_get(8'h02);
    i_cal_fail = 1'b1;
    st_get(8'h12);
    i_cal_fail = 1'b0;
    $display("test gate done");
    for (int s = 0; s < 2; s++) begin
      for (int j = 0; j < 4; j++) cmd(WORD_PUT_CMD, 24, {ADR_SLOPE2 + 8'(j), ws[s][j]});
      chk("cfg", ecfg(s), cfg);
      for (int j = 0; j < 4; j++) wget(ADR_SLOPE2 + 8'(j), ws[s][j]);
    end
    cmd(WORD_PUT_CMD, 24, {8'h0b, 16'h5555});
    wget(8'h0b, 16'h0000);
    $display("test words done");
    st_put(8'h06);
    tw = 1'b1;
    st_get(8'h06);
    wget(ADR_GAIN, ws[1][1]);
    st_put(8'h0a);
    tw = 1'b0;
    $display("test two_wire done");
    cmd(STORAGE_STORE_CMD);
    st_get(8'h0b);
    for (int n = 0; n < 6 && rd[0] !== 1'b0; n++) cmd(STATUS_FETCH_CMD, 0, '0, 8);
    chk("status", 25'h0a, {17'h0, rd[7:0]});
    cmd(WORD_PUT_CMD, 24, {ADR_SLOPE2, 16'h0bad});
    cmd(STORAGE_STORE_CMD);
    cmd(STORAGE_CANCEL_CMD);
    st_get(8'h0a);
    cmd(STORAGE_RECALL_CMD);
    wget(ADR_SLOPE2, 16'h0bad);
    st_put(8'h02);
    cmd(WORD_PUT_CMD, 24, {8'h0a, 16'h00aa});
    cmd(STORAGE_RECALL_CMD);
    wget(ADR_SLOPE2, ws[1][0]);
    wget(8'h0a, 16'h00aa);
    chk("cfg", ecfg(1), cfg);
    $display("test storage done");
    wrap_up();
  end
endmodule : tb_top
